// File: rtl/prim_protect_irq.sv
// Protection release control, interrupt masks, sticky status and interrupt.
`timescale 1ns/1ps
`include "prim_params.svh"
module prim_protect_irq #(
  parameter int DATA_W = 8
) (
  // Clock, reset and enable.
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire logic                ce,
  // Control-port register access.
  input  wire prim_pkg::prim_req_t req,
  output logic [DATA_W-1:0]        reg_rdata,
  output logic                     reg_rvalid,
  // Fault levels from the detectors.
  input  wire prim_pkg::prim_fault_t faults,
  // Protection and interrupt outputs.
  output logic                     speaker_safe,
  output logic                     amp_off,
  output logic                     irq
);
  import prim_pkg::*;

  // The register layouts are byte wide; other widths cannot be served.
  if (DATA_W != 8) begin : g_bad_width
    $error("prim_protect_irq supports DATA_W = 8 only");
  end

  // Software-visible registers.
  logic [7:0] rel_q, rel_d;         // Protection release control.
  logic [7:0] aud_mask_q, aud_mask_d; // Audio source masks.
  logic [7:0] mon_mask_q, mon_mask_d; // Monitor source masks.
  logic [7:0] led_mask_q, led_mask_d; // LED and boost source masks.
  logic [7:0] aud_st_q, aud_st_d;   // Sticky audio status.
  logic [7:0] mon_st_q, mon_st_d;   // Sticky monitor status.
  logic [7:0] led_st_q, led_st_d;   // Sticky LED and boost status.
  logic [7:0] rdata_q, rdata_d;     // Read data register.
  logic       rvalid_q;             // Read answer strobe.
  // Output flops.
  logic       safe_q, amp_off_q, irq_q;
  // Release sequencer results.
  logic       short_prot, short_armed, short_evt;
  logic       otemp_prot, otemp_armed, otemp_evt;
  // Decode and combine wires.
  logic       wr_rel, wr_aud, wr_mon, wr_led;
  logic       rd_aud_st, rd_mon_st, rd_led_st;
  logic [7:0] aud_set, mon_set, led_set;
  logic       pending;

  // Keep only the implemented bits of a written value.
  function automatic logic [7:0] keep_bits(input logic [7:0] v,
                                           input logic [7:0] m);
    keep_bits = v & m;
  endfunction : keep_bits

  // Sticky update: set bits win over a read clear in the same cycle.
  function automatic logic [7:0] sticky(input logic [7:0] q,
                                        input logic       clr,
                                        input logic [7:0] set);
    sticky = (clr ? 8'h00 : q) | set;
  endfunction : sticky

  // Write and read decode.
  assign wr_rel    = req.wr & (req.addr == `PRIM_ADDR_REL);
  assign wr_aud    = req.wr & (req.addr == `PRIM_ADDR_AUD_MASK);
  assign wr_mon    = req.wr & (req.addr == `PRIM_ADDR_MON_MASK);
  assign wr_led    = req.wr & (req.addr == `PRIM_ADDR_LED_MASK);
  assign rd_aud_st = req.rd & (req.addr == `PRIM_ADDR_AUD_STAT);
  assign rd_mon_st = req.rd & (req.addr == `PRIM_ADDR_MON_STAT);
  assign rd_led_st = req.rd & (req.addr == `PRIM_ADDR_LED_STAT);

  // Next register values; reserved bits never store a one.
  assign rel_d = wr_rel ? keep_bits(req.wdata, `PRIM_REL_DEF) : rel_q;
  assign aud_mask_d = wr_aud ? keep_bits(req.wdata, `PRIM_AUD_DEF)
                             : aud_mask_q;
  assign mon_mask_d = wr_mon ? keep_bits(req.wdata, `PRIM_MON_DEF)
                             : mon_mask_q;
  assign led_mask_d = wr_led ? keep_bits(req.wdata, `PRIM_LED_DEF)
                             : led_mask_q;

  // Sources for each sticky status register.
  assign aud_set = {3'b000, faults.serial_clk_err, faults.mclk_err,
                    short_evt, faults.overtemp_warning, otemp_evt};
  assign mon_set = {faults.spk_voltage_ovfl, faults.spk_current_ovfl,
                    faults.battery_mon_ovfl, 4'h0,
                    faults.powerdown_done_flag};
  assign led_set = faults.led_boost_fault;

  // Status bits stay set until software reads them, not until cause ends.
  assign aud_st_d = sticky(aud_st_q, rd_aud_st, aud_set);
  assign mon_st_d = sticky(mon_st_q, rd_mon_st, mon_set);
  assign led_st_d = sticky(led_st_q, rd_led_st, led_set);

  // A mask bit of one blocks its source, zero passes it.
  assign pending = |(aud_st_q & ~aud_mask_q) |
                   |(mon_st_q & ~mon_mask_q) |
                   |(led_st_q & ~led_mask_q);

  // Read multiplexer; unmapped offsets read as zero.
  always_comb begin
    unique case (req.addr)
      `PRIM_ADDR_REL:      rdata_d = rel_q;
      `PRIM_ADDR_AUD_MASK: rdata_d = aud_mask_q;
      `PRIM_ADDR_MON_MASK: rdata_d = mon_mask_q;
      `PRIM_ADDR_LED_MASK: rdata_d = led_mask_q;
      `PRIM_ADDR_AUD_STAT: rdata_d = aud_st_q;
      `PRIM_ADDR_MON_STAT: rdata_d = mon_st_q;
      `PRIM_ADDR_LED_STAT: rdata_d = led_st_q;
      default:             rdata_d = 8'h00;
    endcase
  end

  // Short latch: monitoring is paused while its release runs.
  prim_release_seq #(
    .SUSPEND_MON (1'b1)
  ) u_short_seq (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .ce        (ce),
    .rel_bit   (rel_q[`PRIM_REL_SHORT_BIT]),
    .cond      (faults.amp_output_short_flag),
    .protect_q (short_prot),
    .armed_q   (short_armed),
    .event_q   (short_evt)
  );

  // Overtemperature latch: the error is watched throughout.
  prim_release_seq #(
    .SUSPEND_MON (1'b0)
  ) u_otemp_seq (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .ce        (ce),
    .rel_bit   (rel_q[`PRIM_REL_OTEMP_BIT]),
    .cond      (faults.overtemp_error),
    .protect_q (otemp_prot),
    .armed_q   (otemp_armed),
    .event_q   (otemp_evt)
  );

  // Register file; masks come up all masked, release comes up zero.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rel_q      <= `PRIM_REL_RST;
      aud_mask_q <= `PRIM_AUD_RST;
      mon_mask_q <= `PRIM_MON_RST;
      led_mask_q <= `PRIM_LED_RST;
    end else if (ce) begin
      rel_q      <= rel_d;
      aud_mask_q <= aud_mask_d;
      mon_mask_q <= mon_mask_d;
      led_mask_q <= led_mask_d;
    end
  end

  // Sticky status registers; all bits clear to zero at reset.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      aud_st_q <= `PRIM_STAT_RST;
      mon_st_q <= `PRIM_STAT_RST;
      led_st_q <= `PRIM_STAT_RST;
    end else if (ce) begin
      aud_st_q <= aud_st_d;
      mon_st_q <= mon_st_d;
      led_st_q <= led_st_d;
    end
  end

  // Read answer one cycle after the request.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_q  <= `PRIM_RDATA_RST;
      rvalid_q <= 1'b0;
    end else if (ce) begin
      rdata_q  <= req.rd ? rdata_d : rdata_q;
      rvalid_q <= req.rd;
    end
  end

  // Safe mode is held while either cause is latched; the amplifier is
  // also kept off through a short release so the detector stays quiet.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      safe_q    <= 1'b0;
      amp_off_q <= 1'b0;
      irq_q     <= 1'b0;
    end else if (ce) begin
      safe_q    <= short_prot | otemp_prot;
      amp_off_q <= short_prot | otemp_prot | short_armed;
      irq_q     <= pending;
    end
  end

  assign reg_rdata    = rdata_q;
  assign reg_rvalid   = rvalid_q;
  assign speaker_safe = safe_q;
  assign amp_off      = amp_off_q;
  assign irq          = irq_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Short seen outside a release forces safe mode within two edges.
  sequence s_short_idle;
    ce && faults.amp_output_short_flag && !short_armed &&
      !rel_q[`PRIM_REL_SHORT_BIT];
  endsequence
  property p_short_hold;
    s_short_idle ##1 ce |=> speaker_safe;
  endproperty
  a_short_hold: assert property (p_short_hold)
    else $error("short did not force safe mode");

  // Overtemperature outside a release forces safe mode.
  property p_otemp_hold;
    ce && faults.overtemp_error && !otemp_armed ##1 ce |=> speaker_safe;
  endproperty
  a_otemp_hold: assert property (p_otemp_hold)
    else $error("overtemperature did not force safe mode");

  // The amplifier is off while a short release is in progress.
  property p_amp_off;
    ce && short_armed |=> amp_off;
  endproperty
  a_amp_off: assert property (p_amp_off)
    else $error("amplifier on during short release");

  // Interrupt follows the masked status one cycle later.
  property p_irq;
    ce |=> irq == $past(pending);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt does not follow masked status");

  // With every implemented mask bit high the interrupt stays low.
  property p_all_masked;
    ce && aud_mask_q == `PRIM_AUD_DEF && mon_mask_q == `PRIM_MON_DEF &&
      led_mask_q == `PRIM_LED_DEF |=> !irq;
  endproperty
  a_all_masked: assert property (p_all_masked)
    else $error("interrupt raised with all sources masked");

  // A status bit survives its cause unless read.
  property p_sticky;
    ce && aud_st_q[`PRIM_AUD_OTEMP_BIT] && !rd_aud_st
      |=> aud_st_q[`PRIM_AUD_OTEMP_BIT];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("sticky status bit lost without a read");

  // Reserved release bits never read back as one.
  property p_rel_reserved;
    (rel_q & ~`PRIM_REL_DEF) == 8'h00;
  endproperty
  a_rel_reserved: assert property (p_rel_reserved)
    else $error("reserved release bit set");

  // A short seen at the end of its release re-flags the status bit.
  property p_short_reflag;
    ce && short_armed && !rel_q[`PRIM_REL_SHORT_BIT] &&
      faults.amp_output_short_flag ##1 ce
      |=> aud_st_q[`PRIM_AUD_SHORT_BIT];
  endproperty
  a_short_reflag: assert property (p_short_reflag)
    else $error("short recurrence not re-flagged");

  // A short seen outside a release sets its sticky bit two edges on.
  property p_short_flag;
    s_short_idle ##1 ce |=> aud_st_q[`PRIM_AUD_SHORT_BIT];
  endproperty
  a_short_flag: assert property (p_short_flag)
    else $error("short did not set its status bit");

  // Overtemperature while its release runs is still watched.
  sequence s_otemp_armed;
    ce && otemp_armed && faults.overtemp_error;
  endsequence
  property p_otemp_reflag;
    s_otemp_armed ##1 ce |=> aud_st_q[`PRIM_AUD_OTEMP_BIT];
  endproperty
  a_otemp_reflag: assert property (p_otemp_reflag)
    else $error("overtemperature recurrence not re-flagged");

  // The same recurrence keeps safe mode; the clear must not win.
  property p_otemp_keep;
    s_otemp_armed ##1 ce |=> speaker_safe;
  endproperty
  a_otemp_keep: assert property (p_otemp_keep)
    else $error("safe mode dropped despite overtemperature recurrence");
endmodule : prim_protect_irq

// File: inc/prim_params.svh
// Register offsets, field positions and reset values of the release/mask block.
`ifndef PRIM_PARAMS_SVH
`define PRIM_PARAMS_SVH
// Register offsets on the control port.
`define PRIM_ADDR_REL      8'h11
`define PRIM_ADDR_AUD_MASK 8'h12
`define PRIM_ADDR_MON_MASK 8'h13
`define PRIM_ADDR_LED_MASK 8'h14
`define PRIM_ADDR_AUD_STAT 8'h15
`define PRIM_ADDR_MON_STAT 8'h16
`define PRIM_ADDR_LED_STAT 8'h17
// Field positions in the release register.
`define PRIM_REL_SHORT_BIT 2
`define PRIM_REL_OTEMP_BIT 0
// Field positions in the audio mask and status registers.
`define PRIM_AUD_OTEMP_BIT 0
`define PRIM_AUD_SHORT_BIT 2
// Reset values.
`define PRIM_REL_RST       8'h00
`define PRIM_AUD_RST       8'h1F
`define PRIM_MON_RST       8'hE1
`define PRIM_LED_RST       8'hFF
`define PRIM_STAT_RST      8'h00
`define PRIM_RDATA_RST     8'h00
// Implemented (non-reserved) bits of each register.
`define PRIM_REL_DEF       8'h05
`define PRIM_AUD_DEF       8'h1F
`define PRIM_MON_DEF       8'hE1
`define PRIM_LED_DEF       8'hFF
`endif

// File: inc/prim_pkg.sv
// Types shared by the release/mask block.
package prim_pkg;
  // Raw fault and event levels from the detectors.
  typedef struct packed {
    logic       serial_clk_err;
    logic       mclk_err;
    logic       amp_output_short_flag;
    logic       overtemp_warning;
    logic       overtemp_error;
    logic       spk_voltage_ovfl;
    logic       spk_current_ovfl;
    logic       battery_mon_ovfl;
    logic       powerdown_done_flag;
    logic [7:0] led_boost_fault;
  } prim_fault_t;
  // Control-port request.
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } prim_req_t;
endpackage : prim_pkg

// File: rtl/prim_release_seq.sv
// One protection latch with its low-high-low release sequence.
`timescale 1ns/1ps
module prim_release_seq #(
  parameter bit SUSPEND_MON = 1'b0
) (
  // Clock, reset and enable.
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic ce,
  // Release bit and the protected condition.
  input  wire logic rel_bit,
  input  wire logic cond,
  // Latch state and status-set event.
  output logic      protect_q,
  output logic      armed_q,
  output logic      event_q
);
  logic rel_q;      // Previous release bit value.
  logic recur_q;    // Condition seen during the sequence.
  logic rise, fall, watched, seen, do_clear;

  // Edges of the release bit; only a rise then a fall counts.
  assign rise     = rel_bit & ~rel_q;
  assign fall     = ~rel_bit & rel_q & armed_q;
  // Short monitoring sleeps while the sequence runs, except at its end.
  assign watched  = ~SUSPEND_MON | ~armed_q | fall;
  assign seen     = cond & watched;
  // The clear is decided on the falling edge, from the condition there and recur_q.
  assign do_clear = fall & ~cond & ~recur_q;

  // Sequence tracking and latch update; a fresh condition beats a clear.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rel_q     <= 1'b0;
      armed_q   <= 1'b0;
      recur_q   <= 1'b0;
      protect_q <= 1'b0;
      event_q   <= 1'b0;
    end else if (ce) begin
      rel_q     <= rel_bit;
      armed_q   <= rise | (armed_q & ~fall);
      recur_q   <= armed_q & ~fall & (recur_q | seen);
      protect_q <= seen | (protect_q & ~do_clear);
      event_q   <= seen;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // A clean sequence ending with the condition gone releases the latch.
  property p_clear_on_fall;
    ce && fall && !cond && !recur_q |=> !protect_q;
  endproperty
  a_clear_on_fall: assert property (p_clear_on_fall)
    else $error("latch not released at end of clean sequence");

  // A recurrence inside the sequence keeps the latch set afterwards.
  property p_recur_keeps;
    ce && armed_q && recur_q && fall |=> protect_q;
  endproperty
  a_recur_keeps: assert property (p_recur_keeps)
    else $error("latch released despite recurrence");
endmodule : prim_release_seq

// File: verif/tb_prim_protect_irq.sv
// Self-checking bench for the protection release and interrupt mask block.
`timescale 1ns/1ps
`include "prim_params.svh"
module tb_prim_protect_irq;
  import prim_pkg::*;
  // Clock, reset and enable made by the bench.
  logic        ref_clk;
  logic        rst;
  logic        ce;
  // Control port request and detector levels.
  prim_req_t   req;
  prim_fault_t faults;
  // Outputs of the design.
  logic [7:0]  reg_rdata;
  logic        reg_rvalid;
  logic        speaker_safe;
  logic        amp_off;
  logic        irq;
  // Counters of mismatches and comparisons.
  int          errors;
  int          checks;
  // Per-register tables for the source sweep.
  logic [7:0]  defs [3];
  logic [7:0]  m_adr [3];
  logic [7:0]  s_adr [3];
  int          fi;

  // The block under test.
  prim_protect_irq dut (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .ce           (ce),
    .req          (req),
    .reg_rdata    (reg_rdata),
    .reg_rvalid   (reg_rvalid),
    .faults       (faults),
    .speaker_safe (speaker_safe),
    .amp_off      (amp_off),
    .irq          (irq)
  );

  // A 100 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Compares a seen value with the expected one and counts the result.
  task automatic chk(input string name, input logic [7:0] seen,
                     input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Waits a number of falling edges, where all inputs change.
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc

  // One write; the idle cycle after it keeps the strobe from being reused.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    req.addr  = a;
    req.wdata = d;
    req.wr    = 1'b1;
    cyc(1);
    req.wr    = 1'b0;
    cyc(1);
  endtask : wr_reg

  // One read, compared with the expected byte; the answer wait is bounded.
  task automatic rchk(input string name, input logic [7:0] a,
                      input logic [7:0] exp);
    int i;
    req.addr = a;
    req.rd   = 1'b1;
    cyc(1);
    req.rd   = 1'b0;
    for (i = 0; i < 4 && reg_rvalid !== 1'b1; i++) cyc(1);
    if (reg_rvalid !== 1'b1) begin
      errors++;
      tally_and_finish();
    end
    chk(name, reg_rdata, exp);
    cyc(1);
  endtask : rchk

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("Checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  // Main sequence.
  initial begin
    rst    = 1'b1;
    ce     = 1'b1;
    req    = '0;
    faults = '0;
    errors = 0;
    checks = 0;
    defs   = '{`PRIM_AUD_DEF, `PRIM_MON_DEF, `PRIM_LED_DEF};
    m_adr  = '{`PRIM_ADDR_AUD_MASK, `PRIM_ADDR_MON_MASK, `PRIM_ADDR_LED_MASK};
    s_adr  = '{`PRIM_ADDR_AUD_STAT, `PRIM_ADDR_MON_STAT, `PRIM_ADDR_LED_STAT};
    cyc(6);
    rst = 1'b0;
    cyc(1);
    // Reset values of the release and mask registers, speaker_safe and irq.
    rchk("rel_rst", `PRIM_ADDR_REL, 8'h00);
    rchk("aud_rst", `PRIM_ADDR_AUD_MASK, 8'h1F);
    rchk("mon_rst", `PRIM_ADDR_MON_MASK, 8'hE1);
    rchk("led_rst", `PRIM_ADDR_LED_MASK, 8'hFF);
    chk("safe_rst", speaker_safe, 8'h00);
    chk("irq_rst", irq, 8'h00);
    // A write while the enable is low must not land.
    ce = 1'b0;
    wr_reg(`PRIM_ADDR_AUD_MASK, 8'h00);
    ce = 1'b1;
    rchk("ce_frozen", `PRIM_ADDR_AUD_MASK, 8'h1F);
    // Reserved bits read zero; with all masks open and no status, no irq.
    for (int r = 0; r < 3; r++) begin
      wr_reg(m_adr[r], 8'hFF);
      rchk("mask_rsvd", m_adr[r], defs[r]);
      wr_reg(m_adr[r], 8'h00);
      rchk("mask_zero", m_adr[r], 8'h00);
    end
    chk("irq_none", irq, 8'h00);
    for (int r = 0; r < 3; r++) wr_reg(m_adr[r], defs[r]);
    wr_reg(`PRIM_ADDR_REL, 8'hFA);
    rchk("rel_rsvd", `PRIM_ADDR_REL, 8'h00);
    rchk("unmapped", 8'h20, 8'h00);
    wr_reg(`PRIM_ADDR_LED_STAT, 8'hFF);
    rchk("stat_ro", `PRIM_ADDR_LED_STAT, 8'h00);
    // Each non-latching source: masked pulse, then unmasked sticky irq.
    for (int r = 0; r < 3; r++) begin
      for (int b = 0; b < 8; b++) begin
        if (defs[r][b] && !(r == 0 && (b == 0 || b == 2))) begin
          fi = (r == 0) ? 12 + b : (r == 1) ? ((b == 0) ? 8 : b + 4) : b;
          faults[fi] = 1'b1;
          cyc(1);
          faults[fi] = 1'b0;
          cyc(3);
          chk("irq_masked", irq, 8'h00);
          wr_reg(m_adr[r], defs[r] & ~(8'h01 << b));
          cyc(2);
          chk("irq_open", irq, 8'h01);
          rchk("stat_sticky", s_adr[r], 8'h01 << b);
          cyc(2);
          chk("irq_gone", irq, 8'h00);
          wr_reg(m_adr[r], defs[r]);
        end
      end
    end
    // A short latches safe mode and stays after the short ends.
    faults.amp_output_short_flag = 1'b1;
    cyc(4);
    chk("safe_short", speaker_safe, 8'h01);
    chk("off_short", amp_off, 8'h01);
    faults.amp_output_short_flag = 1'b0;
    cyc(3);
    rchk("short_stat", `PRIM_ADDR_AUD_STAT, 8'h04);
    chk("safe_held", speaker_safe, 8'h01);
    // Writing the release bit low without a rise is no release.
    wr_reg(`PRIM_ADDR_REL, 8'h00);
    cyc(3);
    chk("fall_only", speaker_safe, 8'h01);
    // Short present at the fall keeps protection and flags again.
    wr_reg(`PRIM_ADDR_REL, 8'h04);
    chk("off_armed", amp_off, 8'h01);
    faults.amp_output_short_flag = 1'b1;
    wr_reg(`PRIM_ADDR_REL, 8'h00);
    cyc(3);
    chk("safe_recur", speaker_safe, 8'h01);
    wr_reg(`PRIM_ADDR_AUD_MASK, 8'h1B);
    cyc(2);
    chk("irq_recur", irq, 8'h01);
    faults.amp_output_short_flag = 1'b0;
    cyc(3);
    rchk("stat_recur", `PRIM_ADDR_AUD_STAT, 8'h04);
    wr_reg(`PRIM_ADDR_AUD_MASK, 8'h1F);
    // A short pulse while armed is ignored; a clean sequence clears.
    wr_reg(`PRIM_ADDR_REL, 8'h04);
    faults.amp_output_short_flag = 1'b1;
    cyc(2);
    faults.amp_output_short_flag = 1'b0;
    cyc(1);
    wr_reg(`PRIM_ADDR_REL, 8'h00);
    cyc(3);
    chk("safe_clear", speaker_safe, 8'h00);
    chk("off_clear", amp_off, 8'h00);
    rchk("stat_pause", `PRIM_ADDR_AUD_STAT, 8'h00);
    // Monitoring resumes; overtemperature latches as well.
    faults.amp_output_short_flag = 1'b1;
    faults.overtemp_error        = 1'b1;
    cyc(4);
    chk("safe_both", speaker_safe, 8'h01);
    faults.amp_output_short_flag = 1'b0;
    faults.overtemp_error        = 1'b0;
    cyc(3);
    // Short release alone leaves safe mode while overtemperature holds.
    wr_reg(`PRIM_ADDR_REL, 8'h04);
    wr_reg(`PRIM_ADDR_REL, 8'h00);
    cyc(3);
    chk("safe_otemp", speaker_safe, 8'h01);
    // Status is read twice to confirm the first read clears it.
    rchk("otemp_rd1", `PRIM_ADDR_AUD_STAT, 8'h05);
    rchk("otemp_rd2", `PRIM_ADDR_AUD_STAT, 8'h00);
    // Overtemperature seen while armed blocks the clear.
    wr_reg(`PRIM_ADDR_REL, 8'h01);
    faults.overtemp_error = 1'b1;
    cyc(2);
    faults.overtemp_error = 1'b0;
    cyc(1);
    wr_reg(`PRIM_ADDR_REL, 8'h00);
    cyc(3);
    chk("otemp_recur", speaker_safe, 8'h01);
    rchk("otemp_reflag", `PRIM_ADDR_AUD_STAT, 8'h01);
    // A clean overtemperature sequence ends safe mode.
    wr_reg(`PRIM_ADDR_REL, 8'h01);
    wr_reg(`PRIM_ADDR_REL, 8'h00);
    cyc(3);
    chk("otemp_clear", speaker_safe, 8'h00);
    chk("otemp_off", amp_off, 8'h00);
    // A short release run with nothing latched still keeps the amplifier off.
    wr_reg(`PRIM_ADDR_REL, 8'h04);
    cyc(1);
    chk("off_idle_rel", amp_off, 8'h01);
    chk("safe_idle_rel", speaker_safe, 8'h00);
    wr_reg(`PRIM_ADDR_REL, 8'h00);
    cyc(2);
    chk("on_after_rel", amp_off, 8'h00);
    tally_and_finish();
  end
endmodule : tb_prim_protect_irq
